// [include/ccd_pkg.sv]
package ccd_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int INSTR_W = 14;
  localparam int OFS_INSTR = 32'h0000_0000;
  localparam int OFS_CTRL = 32'h0000_0004;
  localparam int OFS_ACC = 32'h0000_0008;
  localparam int OFS_STATUS = 32'h0000_000C;
  localparam int OFS_FILE_BASE = 32'h0000_0200;
  localparam int OFS_WDT = 32'h0000_0010;
  localparam int CTRL_GO_BIT = 0;
  localparam int ST_NULL_BIT = 2;
  localparam int ST_PD_BIT = 3;
  localparam int ST_TO_BIT = 4;
  localparam int ST_BUSY_BIT = 8;
  localparam int ST_SKIP_BIT = 9;
  localparam int ST_BADOP_BIT = 10;
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [13:0] OP_CLEAR_FILE_REGISTER_OP_MASK = 14'h3F80;
  localparam logic [13:0] OP_CLEAR_FILE_REGISTER_OP_VAL = 14'h0180;
  localparam logic [13:0] OP_CLEAR_ACCUMULATOR_OP_MASK = 14'h3F80;
  localparam logic [13:0] OP_CLEAR_ACCUMULATOR_OP_VAL = 14'h0100;
  localparam logic [13:0] OP_CLEAR_WATCHDOG_OP_VAL = 14'h0064;
  localparam logic [13:0] OP_NIB_MASK = 14'h3F00;
  localparam logic [13:0] OP_COMPLEMENT_FILE_REGISTER_OP_VAL = 14'h0900;
  localparam logic [13:0] OP_DECREMENT_FILE_REGISTER_OP_VAL = 14'h0300;
  localparam logic [13:0] OP_DECREMENT_SKIP_ON_NULL_OP_VAL = 14'h0B00;
  localparam int DEST_BIT = 7;

  typedef enum logic [2:0] {
    CCD_IDLE = 3'b000,
    CCD_Q1 = 3'b001,
    CCD_Q2 = 3'b011,
    CCD_Q3 = 3'b010,
    CCD_Q4 = 3'b110,
    CCD_SKIP = 3'b111
  } ccd_phase_t;

  typedef enum logic [2:0] {
    OP_NONE, OP_CLEAR_FILE_REGISTER_OP, OP_CLEAR_ACCUMULATOR_OP, OP_CLEAR_WATCHDOG_OP, OP_COMPLEMENT_FILE_REGISTER_OP, OP_DECREMENT_FILE_REGISTER_OP, OP_DECREMENT_SKIP_ON_NULL_OP
  } ccd_op_t;
endpackage : ccd_pkg

// [hdl/ccd_core.sv]
// Notes on behaviour
// - Clear-file-register writes zero to the addressed register and sets null flag.
// - Clear-file-register decodes from 00 0001 1 plus seven-bit address.
// - Clear-file-register phases: decode, read register, process, write register.
// - Clear-accumulator decodes from 00 0001 0 with seven don't-care bits.
// - Clear-accumulator loads zero into accumulator and sets null flag.
// - Clear-watchdog resets the watchdog counter to zero.
// - Clear-watchdog also clears the watchdog prescaler.
// - Clear-watchdog sets time-out and power-down status bits to one.
// - Clear-watchdog touches no status flag besides time-out and power-down.
// - Complement inverts the register; destination bit zero writes accumulator.
// - Complement with destination bit one writes back into the register.
// - Complement updates the null flag from its result.
// - Decrement subtracts one and writes the chosen destination.
// - Decrement-and-skip on zero result discards next, runs a one-cycle nop.
module ccd_core
  import ccd_pkg::*;
#(
  parameter int FILE_DEPTH = 128,
  parameter int WDT_W = 8,
  parameter int PRESC_W = 8
) (
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [11:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  output logic BUSY_OUT,
  output logic SKIP_OUT
);

  function automatic ccd_op_t decode_op(input logic [13:0] w);
    if ((w & OP_CLEAR_FILE_REGISTER_OP_MASK) == OP_CLEAR_FILE_REGISTER_OP_VAL) return OP_CLEAR_FILE_REGISTER_OP;
    if ((w & OP_CLEAR_ACCUMULATOR_OP_MASK) == OP_CLEAR_ACCUMULATOR_OP_VAL) return OP_CLEAR_ACCUMULATOR_OP;
    if (w == OP_CLEAR_WATCHDOG_OP_VAL) return OP_CLEAR_WATCHDOG_OP;
    if ((w & OP_NIB_MASK) == OP_COMPLEMENT_FILE_REGISTER_OP_VAL) return OP_COMPLEMENT_FILE_REGISTER_OP;
    if ((w & OP_NIB_MASK) == OP_DECREMENT_FILE_REGISTER_OP_VAL) return OP_DECREMENT_FILE_REGISTER_OP;
    if ((w & OP_NIB_MASK) == OP_DECREMENT_SKIP_ON_NULL_OP_VAL) return OP_DECREMENT_SKIP_ON_NULL_OP;
    return OP_NONE;
  endfunction : decode_op

  logic [7:0] file_mem [FILE_DEPTH];
  logic [13:0] instr_reg, instr_next;
  logic [7:0] acc_reg, acc_next;
  logic [7:0] status_reg, status_next;
  logic [WDT_W-1:0] wdt_reg, wdt_next;
  logic [PRESC_W-1:0] presc_reg, presc_next;
  ccd_phase_t phase_reg, phase_next;
  ccd_op_t op_reg, op_next;
  logic [7:0] opnd_reg, opnd_next;
  logic [7:0] res_reg, res_next;
  logic skip_reg, skip_next;
  logic badop_reg, badop_next;
  logic [31:0] rdat_reg, rdat_next;
  logic ack_reg, ack_next;
  logic fwr_en;
  logic [6:0] fwr_adr;
  logic [7:0] fwr_dat;

  logic [6:0] f_adr;
  logic dest_f;
  logic bus_req;
  assign f_adr = instr_reg[6:0];
  assign dest_f = instr_reg[DEST_BIT];
  assign bus_req = WB_CYC_IN && WB_STB_IN && !ack_reg;

  always_comb begin
    instr_next = instr_reg;
    acc_next = acc_reg;
    status_next = status_reg;
    wdt_next = wdt_reg + 1'b1;
    presc_next = presc_reg;
    phase_next = phase_reg;
    op_next = op_reg;
    opnd_next = opnd_reg;
    res_next = res_reg;
    skip_next = skip_reg;
    badop_next = badop_reg;
    rdat_next = rdat_reg;
    ack_next = 1'b0;
    fwr_en = 1'b0;
    fwr_adr = f_adr;
    fwr_dat = res_reg;
    // Free-running watchdog model; prescaler steps on counter wrap
    if (&wdt_reg) begin
      presc_next = presc_reg + 1'b1;
    end
    case (phase_reg)
      CCD_IDLE: begin
      end
      CCD_Q1: begin
        op_next = decode_op(instr_reg);
        badop_next = (decode_op(instr_reg) == OP_NONE);
        phase_next = CCD_Q2;
      end
      CCD_Q2: begin
        opnd_next = file_mem[f_adr];
        phase_next = CCD_Q3;
      end
      CCD_Q3: begin
        case (op_reg)
          OP_CLEAR_FILE_REGISTER_OP, OP_CLEAR_ACCUMULATOR_OP: res_next = 8'h00;
          OP_COMPLEMENT_FILE_REGISTER_OP: res_next = ~opnd_reg;
          OP_DECREMENT_FILE_REGISTER_OP, OP_DECREMENT_SKIP_ON_NULL_OP: res_next = opnd_reg - 8'h01;
          default: res_next = opnd_reg;
        endcase
        phase_next = CCD_Q4;
      end
      CCD_Q4: begin
        phase_next = CCD_IDLE;
        case (op_reg)
          OP_CLEAR_FILE_REGISTER_OP: begin
            fwr_en = 1'b1;
            status_next[ST_NULL_BIT] = 1'b1;
          end
          OP_CLEAR_ACCUMULATOR_OP: begin
            acc_next = 8'h00;
            status_next[ST_NULL_BIT] = 1'b1;
          end
          OP_CLEAR_WATCHDOG_OP: begin
            wdt_next = '0;
            presc_next = '0;
            status_next[ST_TO_BIT] = 1'b1;
            status_next[ST_PD_BIT] = 1'b1;
          end
          OP_COMPLEMENT_FILE_REGISTER_OP, OP_DECREMENT_FILE_REGISTER_OP, OP_DECREMENT_SKIP_ON_NULL_OP: begin
            if (dest_f) begin
              fwr_en = 1'b1;
            end else begin
              acc_next = res_reg;
            end
            if (op_reg == OP_COMPLEMENT_FILE_REGISTER_OP) begin
              status_next[ST_NULL_BIT] = (res_reg == 8'h00);
            end
            // Status left alone for both decrement forms
            if (op_reg == OP_DECREMENT_SKIP_ON_NULL_OP) begin
              skip_next = (res_reg == 8'h00);
              if (res_reg == 8'h00) begin
                phase_next = CCD_SKIP;
              end
            end
          end
          default: begin
          end
        endcase
      end
      CCD_SKIP: begin
        // Nop cycle standing in for the discarded instruction
        phase_next = CCD_IDLE;
      end
      default: phase_next = CCD_IDLE;
    endcase

    if (bus_req) begin
      ack_next = 1'b1;
      rdat_next = 32'h0000_0000;
      if (WB_WE_IN) begin
        if (WB_ADR_IN == OFS_INSTR[11:0] && phase_reg == CCD_IDLE) begin
          if (WB_SEL_IN[0]) instr_next[7:0] = WB_DAT_IN[7:0];
          if (WB_SEL_IN[1]) instr_next[13:8] = WB_DAT_IN[13:8];
        end else if (WB_ADR_IN == OFS_CTRL[11:0] && WB_SEL_IN[0]) begin
          // Start ignored while busy so a running cycle is never torn
          if (WB_DAT_IN[CTRL_GO_BIT] && phase_reg == CCD_IDLE) begin
            phase_next = CCD_Q1;
            skip_next = 1'b0;
          end
        end else if (WB_ADR_IN == OFS_ACC[11:0] && WB_SEL_IN[0] &&
                     phase_reg == CCD_IDLE) begin
          acc_next = WB_DAT_IN[7:0];
        end else if (WB_ADR_IN == OFS_STATUS[11:0] && WB_SEL_IN[0] &&
                     phase_reg == CCD_IDLE) begin
          status_next = WB_DAT_IN[7:0];
        end else if (WB_ADR_IN[11:9] == OFS_FILE_BASE[11:9] && WB_SEL_IN[0] &&
                     phase_reg == CCD_IDLE && !fwr_en) begin
          fwr_en = 1'b1;
          fwr_adr = WB_ADR_IN[8:2];
          fwr_dat = WB_DAT_IN[7:0];
        end
      end else begin
        if (WB_ADR_IN == OFS_INSTR[11:0]) rdat_next = {18'h0_0000, instr_reg};
        else if (WB_ADR_IN == OFS_ACC[11:0]) rdat_next = {24'h00_0000, acc_reg};
        else if (WB_ADR_IN == OFS_STATUS[11:0]) begin
          rdat_next = {21'h00_0000, badop_reg, skip_reg, phase_reg != CCD_IDLE, status_reg};
        end else if (WB_ADR_IN == OFS_WDT[11:0]) begin
          rdat_next = 32'({presc_reg, wdt_reg});
        end else if (WB_ADR_IN[11:9] == OFS_FILE_BASE[11:9]) begin
          rdat_next = {24'h00_0000, file_mem[WB_ADR_IN[8:2]]};
        end
      end
    end
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      instr_reg <= 14'h0000;
      acc_reg <= ACC_RESET;
      status_reg <= STATUS_RESET;
      wdt_reg <= '0;
      presc_reg <= '0;
      phase_reg <= CCD_IDLE;
      op_reg <= OP_NONE;
      opnd_reg <= 8'h00;
      res_reg <= 8'h00;
      skip_reg <= 1'b0;
      badop_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
      ack_reg <= 1'b0;
    end else begin
      instr_reg <= instr_next;
      acc_reg <= acc_next;
      status_reg <= status_next;
      wdt_reg <= wdt_next;
      presc_reg <= presc_next;
      phase_reg <= phase_next;
      op_reg <= op_next;
      opnd_reg <= opnd_next;
      res_reg <= res_next;
      skip_reg <= skip_next;
      badop_reg <= badop_next;
      rdat_reg <= rdat_next;
      ack_reg <= ack_next;
    end
  end

  // File array has no reset, like ordinary data memory
  always_ff @(posedge REF_CLK_IN) begin
    if (fwr_en) begin
      file_mem[fwr_adr] <= fwr_dat;
    end
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      BUSY_OUT <= 1'b0;
      SKIP_OUT <= 1'b0;
    end else begin
      BUSY_OUT <= (phase_next != CCD_IDLE);
      SKIP_OUT <= skip_next;
    end
  end

  assign WB_DAT_OUT = rdat_reg;
  assign WB_ACK_OUT = ack_reg;

endmodule : ccd_core

// [verif/ccd_core_checker.sv]
module ccd_core_checker
  import ccd_pkg::*;
(
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [11:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic WB_ACK_OUT,
  input wire logic BUSY_OUT,
  input wire logic SKIP_OUT
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);
  logic req;
  logic go;
  assign req = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  assign go = req && WB_WE_IN && WB_ADR_IN == OFS_CTRL[11:0] && WB_SEL_IN[0] && WB_DAT_IN[0];
  a_ack_after_req: assert property (req |=> WB_ACK_OUT)
    else $error("ack missing");
  a_ack_single: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack held");
  a_no_spurious_ack: assert property (!(WB_CYC_IN && WB_STB_IN) |=> !WB_ACK_OUT)
    else $error("ack without request");
  a_go_starts_busy: assert property (go && !BUSY_OUT |=> BUSY_OUT)
    else $error("start lost");
  a_busy_four: assert property ($rose(BUSY_OUT) |-> BUSY_OUT[*4] ##[1:2] !BUSY_OUT)
    else $error("bad busy length");
  a_long_only_skip: assert property ($fell(BUSY_OUT) && $past(BUSY_OUT, 5) |-> SKIP_OUT)
    else $error("extra cycle without skip");
  a_skip_clr_start: assert property ($rose(BUSY_OUT) |-> !SKIP_OUT)
    else $error("skip not cleared");
  a_skip_only_busy: assert property ($changed(SKIP_OUT) |-> BUSY_OUT || $past(BUSY_OUT))
    else $error("skip moved while idle");
  c_skip: cover property ($rose(SKIP_OUT));
  c_done: cover property ($fell(BUSY_OUT));
  c_read: cover property (WB_ACK_OUT && !WB_WE_IN);
endmodule : ccd_core_checker

// [verif/tb_clear_complement_decrement_ops.sv]
module tb_clear_complement_decrement_ops
  import ccd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, cyc, stb, we, ack, busy, skip;
  logic [11:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, dout, rdat;
  logic [7:0] v, r;
  logic [6:0] f;
  int n_errors, tests_run, seed;

  ccd_core u_ccd_core (.REF_CLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(dout),
    .WB_ACK_OUT(ack), .BUSY_OUT(busy), .SKIP_OUT(skip));

  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end

  task automatic stop_test;
    if (n_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  // Request held until ack is sampled, then released for a cycle
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    rdat = dout;
    if (ack !== 1'b1) begin
      n_errors++;
      stop_test();
    end
    cyc <= 0;
    stb <= 0;
  endtask : bus

  task automatic run(input logic [13:0] op);
    int i;
    bus(1, OFS_INSTR[11:0], {18'h0_0000, op});
    bus(1, OFS_CTRL[11:0], 32'h0000_0001);
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (busy !== 1'b0 && i < 20);
    if (busy !== 1'b0) begin
      n_errors++;
      stop_test();
    end
  endtask : run

  function automatic logic [11:0] fa(input logic [6:0] a);
    return {3'b001, a, 2'b00};
  endfunction : fa

  function automatic logic [7:0] st_after(input logic [7:0] s, input logic [7:0] res);
    return (res == 8'h00) ? (s | 8'h04) : (s & 8'hFB);
  endfunction : st_after

  initial begin
    {cyc, stb, we, adr, wdat} = '0;
    sel = 4'hF;
    rst = 1;
    seed = 32'h0000_38ad;
    n_errors = 0;
    tests_run = 0;
    repeat (2) @(posedge clk);
    rst <= 0;
    bus(0, OFS_STATUS[11:0], 8'h00);
    check(STATUS_RESET, rdat[7:0]);
    bus(0, 12'h0100, 8'h00);
    check(8'h00, rdat[7:0]);
    for (int k = 0; k < 6; k++) begin
      f = 7'($random(seed));
      v = (k == 0) ? 8'hFF : (k == 1) ? 8'h01 : 8'($random(seed));
      r = 8'($random(seed));
      bus(1, fa(f), v);
      bus(1, OFS_STATUS[11:0], 8'h00);
      run(OP_COMPLEMENT_FILE_REGISTER_OP_VAL | {7'h00, f});
      bus(0, OFS_ACC[11:0], 8'h00);
      check(~v, rdat[7:0]);
      bus(0, OFS_STATUS[11:0], 8'h00);
      check(st_after(8'h00, ~v), rdat[7:0]);
      run(OP_COMPLEMENT_FILE_REGISTER_OP_VAL | 14'h0080 | {7'h00, f});
      bus(0, fa(f), 8'h00);
      check(~v, rdat[7:0]);
      run(OP_DECREMENT_FILE_REGISTER_OP_VAL | 14'h0080 | {7'h00, f});
      bus(0, fa(f), 8'h00);
      check(~v - 8'h01, rdat[7:0]);
      bus(1, fa(f), v);
      bus(1, OFS_STATUS[11:0], r);
      run(OP_DECREMENT_SKIP_ON_NULL_OP_VAL | 14'h0080 | {7'h00, f});
      check({7'h00, v == 8'h01}, {7'h00, skip});
      bus(0, fa(f), 8'h00);
      check(v - 8'h01, rdat[7:0]);
      bus(0, OFS_STATUS[11:0], 8'h00);
      check(r, rdat[7:0]);
      run(OP_CLEAR_FILE_REGISTER_OP_VAL | {7'h00, f});
      bus(0, fa(f), 8'h00);
      check(8'h00, rdat[7:0]);
      bus(0, OFS_STATUS[11:0], 8'h00);
      check(st_after(r, 8'h00), rdat[7:0]);
      bus(1, OFS_STATUS[11:0], r & 8'hFB);
      run(OP_CLEAR_ACCUMULATOR_OP_VAL | {7'h00, r[6:0]});
      bus(0, OFS_ACC[11:0], 8'h00);
      check(8'h00, rdat[7:0]);
      bus(0, OFS_STATUS[11:0], 8'h00);
      check(r | 8'h04, rdat[7:0]);
      bus(1, OFS_STATUS[11:0], r & 8'hE7);
      repeat (k * 50) @(posedge clk);
      run(OP_CLEAR_WATCHDOG_OP_VAL);
      bus(0, OFS_STATUS[11:0], 8'h00);
      check(r | 8'h18, rdat[7:0]);
      bus(0, OFS_WDT[11:0], 8'h00);
      check(8'h00, rdat[15:8]);
      check(8'h01, {7'h00, rdat[7:0] < 8'h14});
    end
    // Undecodable word must flag itself and leave the core idle
    run(14'h3FFF);
    bus(0, OFS_STATUS[11:0], 32'h0000_0000);
    check(8'h04, {5'h00, rdat[10:8]});
    stop_test();
  end

  // A hang ends the run with a counted mismatch
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    stop_test();
  end
endmodule : tb_clear_complement_decrement_ops

bind ccd_core ccd_core_checker u_ccd_core_checker (.REF_CLK_IN, .RST_IN, .WB_CYC_IN, .WB_STB_IN,
  .WB_WE_IN, .WB_ADR_IN, .WB_SEL_IN, .WB_DAT_IN, .WB_DAT_OUT, .WB_ACK_OUT, .BUSY_OUT, .SKIP_OUT);
